// [iosel_defs.svh]
// Constants of the signal line function selector: addresses, codes, reset values.
// Assumes inclusion by bare name; definitions only.
//
// Contract
// RULE_01: Each line has a 16-bit selector; code 1 is a report-only general input.
// RULE_02: Code 2 is fault reset input, acting only in local control mode.
// RULE_03: Code 3 is power stage enable input, acting only in local control mode.
// RULE_04: Code 4 is an input that triggers halt.
// RULE_05: Code 9 is jog positive input, code 10 jog negative input.
// RULE_06: Code 11 is an input toggling jog between slow and fast speed. The code does not toggle: jog_fast_sel follows the line level.
// RULE_07: Code 20 is reference switch input, accepted on all four lines.
// RULE_08: Code 21, positive limit input, is selectable on line one only.
// RULE_09: Code 22, negative limit input, is selectable on line two only.
// RULE_10: Code 101 makes a general output driven by the output set register.
// RULE_11: Code 102 makes an output showing absence of a fault.
// RULE_12: Code 103 makes a ready output showing operation enabled state.
// RULE_13: Status register shows every line level, line one in bit 0.
// RULE_14: Output set bits reach a pin only when that line selects code 101.
// RULE_15: Reset defaults: positive limit, negative limit, general input, reference switch.
// RULE_16: A selector write with a code not allowed on that line is rejected.
`ifndef IOSEL_DEFS_SVH
`define IOSEL_DEFS_SVH

`define IOSEL_ADDR_SEL1     16'h0722
`define IOSEL_ADDR_SEL2     16'h0724
`define IOSEL_ADDR_SEL3     16'h0726
`define IOSEL_ADDR_SEL4     16'h0728
`define IOSEL_ADDR_OUTSET   16'h0822
`define IOSEL_ADDR_STATUS   16'h082A

`define IOSEL_F_GP_IN       16'h0001
`define IOSEL_F_FAULT_RST   16'h0002
`define IOSEL_F_ENABLE      16'h0003
`define IOSEL_F_HALT        16'h0004
`define IOSEL_F_JOG_POS     16'h0009
`define IOSEL_F_JOG_NEG     16'h000A
`define IOSEL_F_JOG_FAST    16'h000B
`define IOSEL_F_REF         16'h0014
`define IOSEL_F_LIM_POS     16'h0015
`define IOSEL_F_LIM_NEG     16'h0016
`define IOSEL_F_GP_OUT      16'h0065
`define IOSEL_F_NO_FAULT    16'h0066
`define IOSEL_F_READY       16'h0067

`define IOSEL_RST_SEL1      16'h0015
`define IOSEL_RST_SEL2      16'h0016
`define IOSEL_RST_SEL3      16'h0001
`define IOSEL_RST_SEL4      16'h0014
`define IOSEL_RST_OUTSET    4'h0

`define IOSEL_NUM_LINES     4

`endif

// [iosel_pkg.sv]
// Types and the per-line code acceptance check of the line function selector.
// Assumes iosel_defs.svh is on the include path.
`include "iosel_defs.svh"

package iosel_pkg;

    typedef logic [15:0] iosel_code_t;

    typedef enum logic [15:0] {
        IOSEL_GP_IN     = `IOSEL_F_GP_IN,
        IOSEL_FAULT_RST = `IOSEL_F_FAULT_RST,
        IOSEL_ENABLE    = `IOSEL_F_ENABLE,
        IOSEL_HALT      = `IOSEL_F_HALT,
        IOSEL_JOG_POS   = `IOSEL_F_JOG_POS,
        IOSEL_JOG_NEG   = `IOSEL_F_JOG_NEG,
        IOSEL_JOG_FAST  = `IOSEL_F_JOG_FAST,
        IOSEL_REF       = `IOSEL_F_REF,
        IOSEL_LIM_POS   = `IOSEL_F_LIM_POS,
        IOSEL_LIM_NEG   = `IOSEL_F_LIM_NEG,
        IOSEL_GP_OUT    = `IOSEL_F_GP_OUT,
        IOSEL_NO_FAULT  = `IOSEL_F_NO_FAULT,
        IOSEL_READY     = `IOSEL_F_READY
    } iosel_func_e;

    // Limit codes belong to one line each; every other defined code is common to all, and undefined codes are rejected
    function automatic logic iosel_code_ok(input iosel_code_t code, input logic [1:0] idx);
        logic ok;
        ok = 1'b0;
        case (code)
            `IOSEL_F_GP_IN, `IOSEL_F_FAULT_RST, `IOSEL_F_ENABLE, `IOSEL_F_HALT,
            `IOSEL_F_JOG_POS, `IOSEL_F_JOG_NEG, `IOSEL_F_JOG_FAST, `IOSEL_F_REF,
            `IOSEL_F_GP_OUT, `IOSEL_F_NO_FAULT, `IOSEL_F_READY: ok = 1'b1;
            `IOSEL_F_LIM_POS: ok = (idx == 2'd0);
            `IOSEL_F_LIM_NEG: ok = (idx == 2'd1);
            default: ok = 1'b0;
        endcase
        return ok;
    endfunction

endpackage

// [iosel_line_if.sv]
// Carrier between the selector top and one line decoder.
// Assumes the top drives the inputs of the line modport.
`timescale 1ns/100ps
`default_nettype none

interface iosel_line_if;
    logic [15:0] code;
    logic        pad_in;
    logic        out_set;
    logic        local_mode;
    logic        fault_active;
    logic        op_enabled;
    logic        drv_level;
    logic        drv_en;
    logic        act_fault_rst;
    logic        act_enable;
    logic        act_halt;
    logic        act_jog_pos;
    logic        act_jog_neg;
    logic        act_jog_fast;
    logic        act_ref;
    logic        act_lim_pos;
    logic        act_lim_neg;
    logic        level;

    modport line (
        input  code, pad_in, out_set, local_mode, fault_active, op_enabled,
        output drv_level, drv_en, act_fault_rst, act_enable, act_halt, act_jog_pos,
        output act_jog_neg, act_jog_fast, act_ref, act_lim_pos, act_lim_neg, level
    );
    modport top (
        output code, pad_in, out_set, local_mode, fault_active, op_enabled,
        input  drv_level, drv_en, act_fault_rst, act_enable, act_halt, act_jog_pos,
        input  act_jog_neg, act_jog_fast, act_ref, act_lim_pos, act_lim_neg, level
    );
endinterface

`default_nettype wire

// [iosel_line.sv]
// Decoder for one signal line: turns its selector code into a drive or an action.
// Assumes the code was already accepted for this line; purely combinational.
`timescale 1ns/100ps
`default_nettype none
`include "iosel_defs.svh"

module iosel_line #(
    parameter int unsigned LINE_IDX = 0
) (
    iosel_line_if.line lif // Line carrier
);

    if (LINE_IDX >= `IOSEL_NUM_LINES) begin : g_chk
        $error("iosel_line: LINE_IDX out of range");
    end

    always_comb begin
        lif.drv_level     = 1'b0;
        lif.drv_en        = 1'b0;
        lif.act_fault_rst = 1'b0;
        lif.act_enable    = 1'b0;
        lif.act_halt      = 1'b0;
        lif.act_jog_pos   = 1'b0;
        lif.act_jog_neg   = 1'b0;
        lif.act_jog_fast  = 1'b0;
        lif.act_ref       = 1'b0;
        lif.act_lim_pos   = 1'b0;
        lif.act_lim_neg   = 1'b0;
        case (lif.code)
            `IOSEL_F_GP_IN:     ; // RULE_01
            `IOSEL_F_FAULT_RST: lif.act_fault_rst = lif.pad_in & lif.local_mode; // RULE_02
            `IOSEL_F_ENABLE:    lif.act_enable = lif.pad_in & lif.local_mode; // RULE_03
            `IOSEL_F_HALT:      lif.act_halt = lif.pad_in; // RULE_04
            `IOSEL_F_JOG_POS:   lif.act_jog_pos = lif.pad_in; // RULE_05
            `IOSEL_F_JOG_NEG:   lif.act_jog_neg = lif.pad_in; // RULE_05
            `IOSEL_F_JOG_FAST:  lif.act_jog_fast = lif.pad_in; // RULE_06
            `IOSEL_F_REF:       lif.act_ref = lif.pad_in; // RULE_07
            `IOSEL_F_LIM_POS:   lif.act_lim_pos = lif.pad_in; // RULE_08
            `IOSEL_F_LIM_NEG:   lif.act_lim_neg = lif.pad_in; // RULE_09
            `IOSEL_F_GP_OUT: begin
                lif.drv_en    = 1'b1;
                lif.drv_level = lif.out_set; // RULE_10 RULE_14
            end
            `IOSEL_F_NO_FAULT: begin
                lif.drv_en    = 1'b1;
                lif.drv_level = ~lif.fault_active; // RULE_11
            end
            `IOSEL_F_READY: begin
                lif.drv_en    = 1'b1;
                lif.drv_level = lif.op_enabled; // RULE_12
            end
            default: ;
        endcase
        lif.level = lif.drv_en ? lif.drv_level : lif.pad_in; // RULE_13
    end

endmodule

`default_nettype wire

// [iosel_top.sv]
// Function selector for four bidirectional signal lines with its parameter port.
// Assumes a parameter port with one-cycle request pulses; all inputs except rst_b synchronous to clk_sys.
`timescale 1ns/100ps
`default_nettype none
`include "iosel_defs.svh"

module iosel_top #(
    parameter int unsigned NUM_LINES = `IOSEL_NUM_LINES
) (
    input  wire logic        clk_sys,              // System clock, 100 MHz
    input  wire logic        rst_b,                // Asynchronous reset, active low
    input  wire logic        par_req,              // Parameter access request pulse
    input  wire logic        par_we,               // Access is a write
    input  wire logic [15:0] par_addr,             // Parameter address
    input  wire logic [15:0] par_wdata,            // Write data
    output logic      [15:0] par_rdata,            // Read data
    output logic             par_ack,              // Access answered
    output logic             par_err,              // Unmapped address, rejected code or status write
    input  wire logic [3:0]  line_in,              // Line pin levels
    output logic      [3:0]  line_out,             // Line drive levels
    output logic      [3:0]  line_oe,              // Line drive enables
    input  wire logic        local_mode,           // Drive in local control mode
    input  wire logic        fault_active,         // Drive has an error pending
    input  wire logic        op_enabled,           // Drive in operation enabled state
    output logic             fault_reset_req,      // Fault reset input active
    output logic             power_enable_req,     // Power stage enable input active
    output logic             halt_req,             // Halt input active
    output logic             jog_pos_req,          // Jog positive input active
    output logic             jog_neg_req,          // Jog negative input active
    output logic             jog_fast_sel,         // Jog fast selected
    output logic             reference_switch,     // Reference switch level
    output logic             positive_limit_input, // Positive limit switch level
    output logic             negative_limit_input  // Negative limit switch level
);

    if (NUM_LINES != `IOSEL_NUM_LINES) begin : g_chk
        $error("iosel_top: only four lines are supported");
    end

    logic rst_meta;
    logic rst_n;

    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            rst_meta <= 1'b0;
            rst_n    <= 1'b0;
        end else begin
            rst_meta <= 1'b1;
            rst_n    <= rst_meta;
        end
    end

    iosel_pkg::iosel_code_t sel      [4];
    iosel_pkg::iosel_code_t next_sel [4];
    logic [3:0]             out_set;
    logic [3:0]             next_out_set;
    logic [15:0]            next_rdata;
    logic                   next_err;
    logic [1:0]             acc_idx;
    logic [3:0]             lvl;
    logic [3:0]             v_lvl;
    logic [3:0]             v_out;
    logic [3:0]             v_oe;
    logic [3:0]             v_frst;
    logic [3:0]             v_en;
    logic [3:0]             v_halt;
    logic [3:0]             v_jp;
    logic [3:0]             v_jn;
    logic [3:0]             v_jf;
    logic [3:0]             v_ref;
    logic [3:0]             v_lp;
    logic [3:0]             v_ln;

    iosel_line_if lif [4] ();

    for (genvar i = 0; i < 4; i++) begin : g_line
        assign lif[i].code         = sel[i];
        assign lif[i].pad_in       = line_in[i];
        assign lif[i].out_set      = out_set[i];
        assign lif[i].local_mode   = local_mode;
        assign lif[i].fault_active = fault_active;
        assign lif[i].op_enabled   = op_enabled;
        assign v_out[i]            = lif[i].drv_level;
        assign v_oe[i]             = lif[i].drv_en;
        assign v_frst[i]           = lif[i].act_fault_rst;
        assign v_en[i]             = lif[i].act_enable;
        assign v_halt[i]           = lif[i].act_halt;
        assign v_jp[i]             = lif[i].act_jog_pos;
        assign v_jn[i]             = lif[i].act_jog_neg;
        assign v_jf[i]             = lif[i].act_jog_fast;
        assign v_ref[i]            = lif[i].act_ref;
        assign v_lp[i]             = lif[i].act_lim_pos;
        assign v_ln[i]             = lif[i].act_lim_neg;
        assign v_lvl[i]            = lif[i].level;

        iosel_line #(
            .LINE_IDX (i)
        ) u_line (
            .lif (lif[i].line)
        );
    end

    // Register access: one-cycle answer, rejected writes keep the old code
    always_comb begin
        // Selector index from the word address; meaningful on selector addresses only
        acc_idx      = 2'(par_addr[3:1] - 3'd1);
        next_sel     = sel;
        next_out_set = out_set;
        next_rdata   = 16'h0000;
        next_err     = 1'b0;
        if (par_req) begin
            unique case (par_addr)
                `IOSEL_ADDR_SEL1, `IOSEL_ADDR_SEL2, `IOSEL_ADDR_SEL3, `IOSEL_ADDR_SEL4: begin
                    next_rdata = sel[acc_idx];
                    if (par_we) begin
                        if (iosel_pkg::iosel_code_ok(par_wdata, acc_idx)) begin
                            next_sel[acc_idx] = par_wdata; // RULE_01 RULE_07
                        end else begin
                            next_err = 1'b1; // RULE_08 RULE_09 RULE_16
                        end
                    end
                end
                `IOSEL_ADDR_OUTSET: begin
                    next_rdata = {12'h000, out_set};
                    if (par_we) begin
                        next_out_set = par_wdata[3:0];
                    end
                end
                `IOSEL_ADDR_STATUS: begin
                    next_rdata = {12'h000, lvl}; // RULE_13
                    next_err   = par_we;
                end
                default: next_err = 1'b1;
            endcase
        end
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            sel[0]    <= `IOSEL_RST_SEL1; // RULE_15
            sel[1]    <= `IOSEL_RST_SEL2; // RULE_15
            sel[2]    <= `IOSEL_RST_SEL3; // RULE_15
            sel[3]    <= `IOSEL_RST_SEL4; // RULE_15
            out_set   <= `IOSEL_RST_OUTSET;
            par_rdata <= 16'h0000;
            par_ack   <= 1'b0;
            par_err   <= 1'b0;
        end else begin
            sel       <= next_sel;
            out_set   <= next_out_set;
            par_rdata <= next_rdata;
            par_ack   <= par_req;
            par_err   <= next_err;
        end
    end

    // Pin and action outputs, one flop after decode
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            lvl                  <= 4'h0;
            line_out             <= 4'h0;
            line_oe              <= 4'h0;
            fault_reset_req      <= 1'b0;
            power_enable_req     <= 1'b0;
            halt_req             <= 1'b0;
            jog_pos_req          <= 1'b0;
            jog_neg_req          <= 1'b0;
            jog_fast_sel         <= 1'b0;
            reference_switch     <= 1'b0;
            positive_limit_input <= 1'b0;
            negative_limit_input <= 1'b0;
        end else begin
            lvl                  <= v_lvl;
            line_out             <= v_out;
            line_oe              <= v_oe;
            fault_reset_req      <= |v_frst;
            power_enable_req     <= |v_en;
            halt_req             <= |v_halt;
            jog_pos_req          <= |v_jp;
            jog_neg_req          <= |v_jn;
            jog_fast_sel         <= |v_jf;
            reference_switch     <= |v_ref;
            positive_limit_input <= |v_lp;
            negative_limit_input <= |v_ln;
        end
    end

    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rst_n);

    property p_sel_write_taken;
        par_req && par_we && par_addr == `IOSEL_ADDR_SEL3 && par_wdata == `IOSEL_F_HALT
            |=> sel[2] == `IOSEL_F_HALT && par_ack && !par_err;
    endproperty
    a_sel_write_taken: assert property (p_sel_write_taken) else $error("selector write lost"); // RULE_01

    property p_fault_rst_local;
        !local_mode |=> !fault_reset_req;
    endproperty
    a_fault_rst_local: assert property (p_fault_rst_local) else $error("fault reset outside local"); // RULE_02

    property p_enable_local;
        sel[2] == `IOSEL_F_ENABLE && line_in[2] && local_mode |=> power_enable_req;
    endproperty
    a_enable_local: assert property (p_enable_local) else $error("enable input not passed"); // RULE_03

    property p_halt;
        sel[2] == `IOSEL_F_HALT && line_in[2] |=> halt_req;
    endproperty
    a_halt: assert property (p_halt) else $error("halt input not passed"); // RULE_04

    property p_jog_neg;
        sel[2] == `IOSEL_F_JOG_NEG && line_in[2] |=> jog_neg_req && !line_oe[2];
    endproperty
    a_jog_neg: assert property (p_jog_neg) else $error("jog negative not passed"); // RULE_05

    property p_ref_line4;
        sel[3] == `IOSEL_F_REF ##0 line_in[3] |=> reference_switch;
    endproperty
    a_ref_line4: assert property (p_ref_line4) else $error("reference switch not passed"); // RULE_07

    property p_lim_pos_reject;
        par_req && par_we && par_addr == `IOSEL_ADDR_SEL3 && par_wdata == `IOSEL_F_LIM_POS
            |=> par_err && sel[2] == $past(sel[2]);
    endproperty
    a_lim_pos_reject: assert property (p_lim_pos_reject) else $error("limit code taken"); // RULE_08

    property p_lim_neg_reject;
        par_req && par_we && par_addr == `IOSEL_ADDR_SEL1 && par_wdata == `IOSEL_F_LIM_NEG
            |=> par_err && sel[0] == $past(sel[0]);
    endproperty
    a_lim_neg_reject: assert property (p_lim_neg_reject) else $error("limit code taken"); // RULE_09

    property p_gp_out;
        sel[3] == `IOSEL_F_GP_OUT |=> line_oe[3] && line_out[3] == $past(out_set[3]);
    endproperty
    a_gp_out: assert property (p_gp_out) else $error("output set not driven"); // RULE_10

    property p_no_fault;
        sel[3] == `IOSEL_F_NO_FAULT |=> line_oe[3] && line_out[3] == !$past(fault_active);
    endproperty
    a_no_fault: assert property (p_no_fault) else $error("no fault output wrong"); // RULE_11

    property p_ready;
        sel[3] == `IOSEL_F_READY |=> line_oe[3] && line_out[3] == $past(op_enabled);
    endproperty
    a_ready: assert property (p_ready) else $error("ready output wrong"); // RULE_12

    property p_status;
        par_req && !par_we && par_addr == `IOSEL_ADDR_STATUS
            |=> par_rdata == {12'h000, $past(lvl)};
    endproperty
    a_status: assert property (p_status) else $error("status read wrong"); // RULE_13

    property p_out_only_gp;
        sel[2] != `IOSEL_F_GP_OUT && sel[2] != `IOSEL_F_NO_FAULT && sel[2] != `IOSEL_F_READY
            |=> !line_oe[2];
    endproperty
    a_out_only_gp: assert property (p_out_only_gp) else $error("input line driven"); // RULE_14

    property p_defaults;
        $rose(rst_n) |-> sel[0] == `IOSEL_RST_SEL1 && sel[1] == `IOSEL_RST_SEL2
            && sel[2] == `IOSEL_RST_SEL3 && sel[3] == `IOSEL_RST_SEL4;
    endproperty
    a_defaults: assert property (disable iff (1'b0) p_defaults) else $error("bad defaults"); // RULE_15

    property p_bad_code;
        par_req && par_we && par_addr == `IOSEL_ADDR_SEL3 && par_wdata == 16'h0005
            |=> par_err ##1 sel[2] == $past(sel[2], 2);
    endproperty
    a_bad_code: assert property (p_bad_code) else $error("illegal code taken"); // RULE_16

endmodule

`default_nettype wire

// [iosel_switch_model.sv]
// Far side of the four signal lines: switches and external control signals.
// Assumes the bench sets the switch levels; a driven line shows the device's level.
`timescale 1ns/100ps
`default_nettype none

module iosel_switch_model (
    input  wire logic [3:0] sw_level, // Switch or external signal level per line
    input  wire logic [3:0] line_out, // Device drive level
    input  wire logic [3:0] line_oe,  // Device drive enable
    output logic      [3:0] line_in   // Resolved wire level
);
    // A line that the device drives carries the device's level
    always_comb begin
        for (int i = 0; i < 4; i++) begin
            line_in[i] = line_oe[i] ? line_out[i] : sw_level[i];
        end
    end
endmodule

`default_nettype wire

// [io_line_function_selector_test.sv]
// Self-checking bench of the signal line function selector.
// Assumes iosel_defs.svh on the include path and the switch model compiled before.
`timescale 1ns/100ps
`default_nettype none
`include "iosel_defs.svh"

module io_line_function_selector_test;
    logic clk_sys = 1'b0, rst_b = 1'b0, par_req = 1'b0, par_we = 1'b0;
    logic [15:0] par_addr = 16'h0000, par_wdata = 16'h0000, par_rdata, rd;
    logic par_ack, par_err, local_mode = 1'b0, fault_active = 1'b0, op_enabled = 1'b0;
    logic [3:0] sw = 4'h0, line_in, line_out, line_oe;
    logic [8:0] act;
    int n_mismatch = 0;
    int comparisons = 0;

    always #5 clk_sys = ~clk_sys;

    iosel_top i_dut (
        .clk_sys(clk_sys), .rst_b(rst_b), .par_req(par_req), .par_we(par_we),
        .par_addr(par_addr), .par_wdata(par_wdata), .par_rdata(par_rdata),
        .par_ack(par_ack), .par_err(par_err), .line_in(line_in), .line_out(line_out),
        .line_oe(line_oe), .local_mode(local_mode), .fault_active(fault_active),
        .op_enabled(op_enabled), .fault_reset_req(act[8]), .power_enable_req(act[7]),
        .halt_req(act[6]), .jog_pos_req(act[5]), .jog_neg_req(act[4]),
        .jog_fast_sel(act[3]), .reference_switch(act[2]),
        .positive_limit_input(act[1]), .negative_limit_input(act[0])
    );

    iosel_switch_model i_far (
        .sw_level(sw), .line_out(line_out), .line_oe(line_oe), .line_in(line_in)
    );

    task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
        comparisons++;
        if (got !== exp) begin
            n_mismatch++;
            $display("unexpected %s: expected %h, seen %h", what, exp, got);
        end
    endtask

    // One access; answer is sampled in the cycle after the taking edge
    task automatic bus(input logic we, input logic [15:0] a, d, input logic e);
        @(posedge clk_sys);
        par_req <= 1'b1;
        par_we <= we;
        par_addr <= a;
        par_wdata <= d;
        @(posedge clk_sys);
        par_req <= 1'b0;
        #1;
        rd = par_rdata;
        chk("ack", 16'h0001, {15'h0000, par_ack});
        chk("err", {15'h0000, e}, {15'h0000, par_err});
    endtask

    task automatic rd_chk(input logic [15:0] a, exp);
        bus(1'b0, a, 16'h0000, 1'b0);
        chk("read", exp, rd);
    endtask

    task automatic settle();
        repeat (3) @(posedge clk_sys);
        #1;
    endtask

    task automatic t_defaults();
        rd_chk(`IOSEL_ADDR_SEL1, `IOSEL_RST_SEL1);
        rd_chk(`IOSEL_ADDR_SEL2, `IOSEL_RST_SEL2);
        rd_chk(`IOSEL_ADDR_SEL3, `IOSEL_RST_SEL3);
        rd_chk(`IOSEL_ADDR_SEL4, `IOSEL_RST_SEL4);
        sw <= 4'b1011;
        settle();
        chk("actions", 16'h0007, {7'h00, act});
        chk("drive", 16'h0000, {8'h00, line_oe, line_out});
        rd_chk(`IOSEL_ADDR_STATUS, 16'h000B);
    endtask

    task automatic t_reject();
        bus(1'b1, `IOSEL_ADDR_SEL3, `IOSEL_F_LIM_POS, 1'b1);
        bus(1'b1, `IOSEL_ADDR_SEL4, `IOSEL_F_LIM_NEG, 1'b1);
        bus(1'b1, `IOSEL_ADDR_SEL2, `IOSEL_F_LIM_POS, 1'b1);
        bus(1'b1, `IOSEL_ADDR_SEL1, `IOSEL_F_LIM_NEG, 1'b1);
        bus(1'b1, `IOSEL_ADDR_SEL3, 16'h0005, 1'b1);
        rd_chk(`IOSEL_ADDR_SEL1, `IOSEL_F_LIM_POS);
        rd_chk(`IOSEL_ADDR_SEL2, `IOSEL_F_LIM_NEG);
        rd_chk(`IOSEL_ADDR_SEL3, `IOSEL_F_GP_IN);
        rd_chk(`IOSEL_ADDR_SEL4, `IOSEL_F_REF);
        bus(1'b1, `IOSEL_ADDR_STATUS, 16'h000F, 1'b1);
        bus(1'b0, 16'h0730, 16'h0000, 1'b1);
        chk("unmapped", 16'h0000, rd);
    endtask

    // Each input code except the two limit codes on line three, with and without local control mode
    task automatic t_inputs();
        logic [15:0] codes [8] = '{`IOSEL_F_GP_IN, `IOSEL_F_FAULT_RST, `IOSEL_F_ENABLE,
            `IOSEL_F_HALT, `IOSEL_F_JOG_POS, `IOSEL_F_JOG_NEG, `IOSEL_F_JOG_FAST, `IOSEL_F_REF};
        int bits [8] = '{9, 8, 7, 6, 5, 4, 3, 2};
        logic [8:0] exp;
        for (int i = 0; i < 8; i++) begin
            bus(1'b1, `IOSEL_ADDR_SEL3, codes[i], 1'b0);
            exp = (bits[i] < 9) ? (9'h001 << bits[i]) : 9'h000;
            for (int m = 0; m < 2; m++) begin
                local_mode <= m[0];
                sw <= 4'b0100;
                settle();
                chk("line3 act", {7'h00, (m == 0 && bits[i] > 6) ? 9'h000 : exp},
                    {7'h00, act});
                sw <= 4'b0000;
                settle();
                chk("line3 idle", 16'h0000, {7'h00, act});
            end
        end
        bus(1'b1, `IOSEL_ADDR_SEL3, `IOSEL_F_GP_IN, 1'b0);
    endtask

    task automatic t_outputs();
        bus(1'b1, `IOSEL_ADDR_SEL4, `IOSEL_F_GP_OUT, 1'b0);
        bus(1'b1, `IOSEL_ADDR_OUTSET, 16'h000C, 1'b0);
        settle();
        chk("gp out", 16'h0088, {8'h00, line_oe, line_out});
        rd_chk(`IOSEL_ADDR_STATUS, 16'h0008);
        bus(1'b1, `IOSEL_ADDR_OUTSET, 16'h0004, 1'b0);
        settle();
        chk("gp out low", 16'h0080, {8'h00, line_oe, line_out});
        bus(1'b1, `IOSEL_ADDR_SEL4, `IOSEL_F_NO_FAULT, 1'b0);
        settle();
        chk("no fault", 16'h0088, {8'h00, line_oe, line_out});
        fault_active <= 1'b1;
        settle();
        chk("fault", 16'h0080, {8'h00, line_oe, line_out});
        bus(1'b1, `IOSEL_ADDR_SEL4, `IOSEL_F_READY, 1'b0);
        op_enabled <= 1'b1;
        settle();
        chk("ready", 16'h0088, {8'h00, line_oe, line_out});
        op_enabled <= 1'b0;
        settle();
        chk("not ready", 16'h0080, {8'h00, line_oe, line_out});
    endtask

    task automatic print_verdict();
        $display("comparisons %0d, n_mismatch %0d", comparisons, n_mismatch);
        if (n_mismatch == 0 && comparisons > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    initial begin
        repeat (2) @(posedge clk_sys);
        rst_b <= 1'b1;
        repeat (3) @(posedge clk_sys);
        t_defaults();
        t_reject();
        t_inputs();
        t_outputs();
        print_verdict();
    end

    initial begin
        #100000;
        n_mismatch++;
        print_verdict();
    end
endmodule

`default_nettype wire
